// file: logic/loop_ctrl_pkg.sv
// package: offsets, field positions, reset values and mode codes of the loop control bank
// assumes: byte-wide registers on a 32-bit classic wishbone bus, one word per register
`default_nettype none

package loop_ctrl_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [11:0] IDX_POWER_DOWN_CONTROL = 12'h0a00;
  localparam logic [11:0] IDX_LOOP_MODE_CONTROL  = 12'h0a01;
  localparam logic [13:0] ADR_POWER_DOWN_CONTROL = {IDX_POWER_DOWN_CONTROL, 2'b00};
  localparam logic [13:0] ADR_LOOP_MODE_CONTROL  = {IDX_LOOP_MODE_CONTROL, 2'b00};

  // ==========================================================================
  // power_down_control fields
  localparam int PD_SOFT_RESET  = 7;
  localparam int PD_OSC         = 6;
  localparam int PD_SYS_CLOCK   = 5;
  localparam int PD_REF_INPUTS  = 4;
  localparam int PD_TIME_CONV   = 3;
  localparam int PD_OUTPUT_PLL  = 2;
  localparam int PD_CLOCK_DIST  = 1;
  localparam int PD_FULL        = 0;

  // ==========================================================================
  // loop_mode_control fields
  localparam int LM_RESERVED    = 7;
  localparam int LM_HOLDOVER    = 6;
  localparam int LM_FREERUN     = 5;
  localparam int LM_SWITCH_HI   = 4;
  localparam int LM_SWITCH_LO   = 2;
  localparam int LM_REF_SELECT  = 0;
  localparam logic [7:0] LM_WRITE_MASK = 8'h7d;

  localparam logic [7:0] POWER_DOWN_RESET = 8'h00;
  localparam logic [7:0] LOOP_MODE_RESET  = 8'h00;

  // soft reset pulse length in clocks
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;

  // ==========================================================================
  // switchover mode codes
  localparam logic [2:0] SW_AUTO_REVERTIVE     = 3'h0;
  localparam logic [2:0] SW_AUTO_NON_REVERTIVE = 3'h1;
  localparam logic [2:0] SW_MANUAL_FALLBACK    = 3'h2;
  localparam logic [2:0] SW_MANUAL_HOLDOVER    = 3'h3;
  localparam logic [2:0] SW_FULL_MANUAL        = 3'h4;

  typedef enum logic [2:0] {
    MODE_AUTO_REVERTIVE,
    MODE_AUTO_NON_REVERTIVE,
    MODE_MANUAL_FALLBACK,
    MODE_MANUAL_HOLDOVER,
    MODE_FULL_MANUAL,
    MODE_UNUSED
  } switch_mode_t;

  // tuning word source for the oscillator
  typedef enum logic [1:0] {
    TUNE_LOOP,
    TUNE_HISTORY,
    TUNE_FREE_RUN
  } tune_source_t;

endpackage : loop_ctrl_pkg

`default_nettype wire

// file: logic/loop_ctrl_regs.sv
// operational loop control bank: power-down and loop-mode registers with their decode
// assumes: classic wishbone master on clk_i; history_valid_i is from the same clock domain
`default_nettype none

// Function
// R1 - soft reset bit 7 resets internal state, programmed registers are kept
// R2 - power-down bit 6 puts the controlled oscillator to sleep
// R3 - power-down bit 5 sleeps system clock input and its multiplier pll
// R4 - power-down bit 4 sleeps all reference input receivers
// R5 - power-down bit 3 sleeps the time-to-digital converter
// R6 - power-down bit 2 sleeps the output pll
// R7 - power-down bit 1 sleeps the clock distribution outputs
// R8 - power-down bit 0 sleeps the entire device
// R9 - loop-mode bit 6 forces holdover
// R10 - forced holdover uses history word if present, else free-run word
// R11 - forced holdover holds phase and frequency lock detectors unlocked
// R12 - loop-mode bit 5 forces free run from the free-run word
// R13 - free run wins when both forcing bits are set
// R14 - loop-mode bits 4 to 2 select switchover state machine mode
// R15 - codes 000 revertive, 001 non-revertive, 010 manual fallback, 011 manual holdover
// R16 - code 100 is full manual, 101 to 111 unused
// R17 - in manual modes bit 0 picks first (0) or second (1) reference
// R18 - reserved loop-mode bit 7 reads zero and ignores writes
module loop_ctrl_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [13:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // loop status from the datapath
  input  wire logic        history_valid_i,
  // control to the analog and loop blocks
  output logic             soft_reset_o,
  output logic             osc_sleep_o,
  output logic             system_clock_input_sleep_o,
  output logic             ref_inputs_sleep_o,
  output logic             time_to_digital_converter_sleep_o,
  output logic             output_pll_sleep_o,
  output logic             clock_dist_sleep_o,
  output logic             full_sleep_o,
  output logic             holdover_forced_o,
  output logic             freerun_forced_o,
  output logic [1:0]       tune_source_o,
  output logic             lock_detect_hold_o,
  output logic [2:0]       switch_mode_o,
  output logic             manual_select_o,
  output logic             second_reference_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]  power_down;
    logic [7:0]  loop_mode;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
    logic        soft_start;
    logic [7:0]  sleep;
    logic        hold;
    logic        free;
    logic [1:0]  tune;
    logic        lock_hold;
    logic [2:0]  mode;
    logic        manual;
    logic        second_ref;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic stretched_reset;
  logic req;
  logic hit_pd;
  logic hit_lm;
  logic [7:0] lm_eff;
  loop_ctrl_pkg::switch_mode_t mode_dec;

  assign req    = cyc_i && stb_i && !state_q.ack && !state_q.err;
  assign hit_pd = adr_i == loop_ctrl_pkg::ADR_POWER_DOWN_CONTROL;
  assign hit_lm = adr_i == loop_ctrl_pkg::ADR_LOOP_MODE_CONTROL;

  // ==========================================================================
  // soft reset pulse generator
  soft_reset_stretch u_soft_reset (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (state_q.soft_start),
    .reset_o (stretched_reset)
  );

  always_comb
  begin
    lm_eff = state_q.loop_mode;
    lm_eff[loop_ctrl_pkg::LM_RESERVED] = 1'b0;                                  // [R18]
    unique case (lm_eff[loop_ctrl_pkg::LM_SWITCH_HI:loop_ctrl_pkg::LM_SWITCH_LO]) // [R14]
      loop_ctrl_pkg::SW_AUTO_REVERTIVE:     mode_dec = loop_ctrl_pkg::MODE_AUTO_REVERTIVE;
      loop_ctrl_pkg::SW_AUTO_NON_REVERTIVE: mode_dec = loop_ctrl_pkg::MODE_AUTO_NON_REVERTIVE;
      loop_ctrl_pkg::SW_MANUAL_FALLBACK:    mode_dec = loop_ctrl_pkg::MODE_MANUAL_FALLBACK;
      loop_ctrl_pkg::SW_MANUAL_HOLDOVER:    mode_dec = loop_ctrl_pkg::MODE_MANUAL_HOLDOVER;
      loop_ctrl_pkg::SW_FULL_MANUAL:        mode_dec = loop_ctrl_pkg::MODE_FULL_MANUAL; // [R16]
      default:                              mode_dec = loop_ctrl_pkg::MODE_UNUSED;      // [R16]
    endcase
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    state_d            = state_q;
    state_d.ack        = 1'b0;
    state_d.err        = 1'b0;
    state_d.soft_start = 1'b0;

    // bus access, single cycle answer
    if (req)
    begin
      if (hit_pd || hit_lm)
      begin
        state_d.ack   = 1'b1;
        state_d.rdata = 32'h0000_0000;
        if (we_i && sel_i[0])
        begin
          if (hit_pd)
          begin
            state_d.power_down = dat_i[7:0];
            // writing the bit starts a fresh reset pulse each time
            state_d.soft_start = dat_i[loop_ctrl_pkg::PD_SOFT_RESET];           // [R1]
          end
          else
          begin
            state_d.loop_mode = dat_i[7:0] & loop_ctrl_pkg::LM_WRITE_MASK;      // [R18]
          end
        end
        else if (!we_i)
        begin
          state_d.rdata[7:0] = hit_pd ? state_q.power_down : lm_eff;
        end
      end
      else
      begin
        state_d.err = 1'b1;
      end
    end

    // decoded controls
    state_d.sleep = state_q.power_down;                                         // [R2] [R3] [R4]
    state_d.sleep[loop_ctrl_pkg::PD_SOFT_RESET] = 1'b0;                         // [R5] [R6] [R7]
    if (state_q.power_down[loop_ctrl_pkg::PD_FULL])
    begin
      // full sleep takes every block down with it
      state_d.sleep = 8'h7f;                                                    // [R8]
    end

    state_d.free = lm_eff[loop_ctrl_pkg::LM_FREERUN];                           // [R12]
    state_d.hold = lm_eff[loop_ctrl_pkg::LM_HOLDOVER] && !state_d.free;         // [R9] [R13]
    if (state_d.free)
    begin
      state_d.tune = loop_ctrl_pkg::TUNE_FREE_RUN;                              // [R12]
    end
    else if (state_d.hold)
    begin
      state_d.tune = history_valid_i ? loop_ctrl_pkg::TUNE_HISTORY
                                     : loop_ctrl_pkg::TUNE_FREE_RUN;            // [R10]
    end
    else
    begin
      state_d.tune = loop_ctrl_pkg::TUNE_LOOP;
    end
    // a free-run override also leaves holdover, so the detectors follow hold only
    state_d.lock_hold  = state_d.hold;                                          // [R11]
    state_d.mode       = mode_dec;                                              // [R15]
    state_d.manual     = (mode_dec == loop_ctrl_pkg::MODE_MANUAL_FALLBACK) ||
                         (mode_dec == loop_ctrl_pkg::MODE_MANUAL_HOLDOVER) ||
                         (mode_dec == loop_ctrl_pkg::MODE_FULL_MANUAL);
    state_d.second_ref = state_d.manual && lm_eff[loop_ctrl_pkg::LM_REF_SELECT]; // [R17]

    // soft reset clears internal state only; the register bank survives
    if (stretched_reset)
    begin
      state_d.sleep      = 8'h00;                                               // [R1]
      state_d.tune       = loop_ctrl_pkg::TUNE_LOOP;
      state_d.lock_hold  = 1'b0;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q            <= '0;
      state_q.power_down <= loop_ctrl_pkg::POWER_DOWN_RESET;
      state_q.loop_mode  <= loop_ctrl_pkg::LOOP_MODE_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs
  assign ack_o                      = state_q.ack;
  assign err_o                      = state_q.err;
  assign dat_o                      = state_q.rdata;
  assign soft_reset_o               = stretched_reset;
  assign osc_sleep_o                = state_q.sleep[loop_ctrl_pkg::PD_OSC];
  assign system_clock_input_sleep_o = state_q.sleep[loop_ctrl_pkg::PD_SYS_CLOCK];
  assign ref_inputs_sleep_o         = state_q.sleep[loop_ctrl_pkg::PD_REF_INPUTS];
  assign time_to_digital_converter_sleep_o = state_q.sleep[loop_ctrl_pkg::PD_TIME_CONV];
  assign output_pll_sleep_o         = state_q.sleep[loop_ctrl_pkg::PD_OUTPUT_PLL];
  assign clock_dist_sleep_o         = state_q.sleep[loop_ctrl_pkg::PD_CLOCK_DIST];
  assign full_sleep_o               = state_q.sleep[loop_ctrl_pkg::PD_FULL];
  assign holdover_forced_o          = state_q.hold;
  assign freerun_forced_o           = state_q.free;
  assign tune_source_o              = state_q.tune;
  assign lock_detect_hold_o         = state_q.lock_hold;
  assign switch_mode_o              = state_q.mode;
  assign manual_select_o            = state_q.manual;
  assign second_reference_o         = state_q.second_ref;

endmodule : loop_ctrl_regs

`default_nettype wire

// file: logic/soft_reset_stretch.sv
// stretches a one-clock request into a fixed-length reset pulse
// assumes: request and clock share one domain
`default_nettype none

module soft_reset_stretch (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      reset_o
);

  typedef struct packed {
    logic [3:0] count;
    logic       active;
  } state_t;

  state_t state_q;
  state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (start_i)
    begin
      // a new request restarts the full length
      state_d.count  = loop_ctrl_pkg::SOFT_RESET_CYCLES;
      state_d.active = 1'b1;
    end
    else if (state_q.active)
    begin
      state_d.count = state_q.count - 4'h1;
      if (state_q.count == 4'h1)
      begin
        state_d.active = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign reset_o = state_q.active;

endmodule : soft_reset_stretch

`default_nettype wire

// file: testbench/loop_ctrl_regs_properties.sv
// checker: decode relations of the loop control bank outputs
// assumes: bound to loop_ctrl_regs, one clock, synchronous reset
`default_nettype none

module loop_ctrl_regs_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [13:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        history_valid_i,
  input wire logic        soft_reset_o,
  input wire logic        osc_sleep_o,
  input wire logic        system_clock_input_sleep_o,
  input wire logic        ref_inputs_sleep_o,
  input wire logic        time_to_digital_converter_sleep_o,
  input wire logic        output_pll_sleep_o,
  input wire logic        clock_dist_sleep_o,
  input wire logic        full_sleep_o,
  input wire logic        holdover_forced_o,
  input wire logic        freerun_forced_o,
  input wire logic [1:0]  tune_source_o,
  input wire logic        lock_detect_hold_o,
  input wire logic [2:0]  switch_mode_o,
  input wire logic        manual_select_o,
  input wire logic        second_reference_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // properties
  // soft reset cycles are excluded: the pulse clears the tune and lock outputs, which lag it by a cycle
  property p_read_reserved;
    cyc_i && stb_i && !ack_o && !err_o && !we_i
      && adr_i == loop_ctrl_pkg::ADR_LOOP_MODE_CONTROL |=> ack_o && dat_o[31:7] == 25'h0;
  endproperty
  a_read_reserved: assert property (p_read_reserved) else $error("loop mode read bad");
  property p_soft_len;
    $rose(soft_reset_o) |-> soft_reset_o [*8] ##1 !soft_reset_o;
  endproperty
  a_soft_len: assert property (p_soft_len) else $error("soft reset length");
  property p_full;
    full_sleep_o |-> osc_sleep_o && system_clock_input_sleep_o && ref_inputs_sleep_o
      && time_to_digital_converter_sleep_o && output_pll_sleep_o && clock_dist_sleep_o;
  endproperty
  a_full: assert property (p_full) else $error("full sleep incomplete");
  property p_freerun;
    freerun_forced_o && !soft_reset_o && !$past(soft_reset_o)
      |-> !holdover_forced_o && tune_source_o == 2'h2;
  endproperty
  a_freerun: assert property (p_freerun) else $error("free run source");
  property p_hold_lock;
    holdover_forced_o && !soft_reset_o && !$past(soft_reset_o)
      |-> lock_detect_hold_o && !freerun_forced_o;
  endproperty
  a_hold_lock: assert property (p_hold_lock) else $error("holdover lock");
  property p_hold_src;
    holdover_forced_o && $past(holdover_forced_o) && !soft_reset_o && !$past(soft_reset_o)
      |-> tune_source_o == ($past(history_valid_i) ? 2'h1 : 2'h2);
  endproperty
  a_hold_src: assert property (p_hold_src) else $error("holdover source");
  property p_manual;
    manual_select_o == (switch_mode_o inside {3'h2, 3'h3, 3'h4});
  endproperty
  a_manual: assert property (p_manual) else $error("manual decode");
  property p_second;
    second_reference_o |-> manual_select_o;
  endproperty
  a_second: assert property (p_second) else $error("second ref outside manual");
endmodule : loop_ctrl_regs_checker

bind loop_ctrl_regs loop_ctrl_regs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .history_valid_i(history_valid_i), .soft_reset_o(soft_reset_o),
  .osc_sleep_o(osc_sleep_o), .system_clock_input_sleep_o(system_clock_input_sleep_o),
  .ref_inputs_sleep_o(ref_inputs_sleep_o),
  .time_to_digital_converter_sleep_o(time_to_digital_converter_sleep_o),
  .output_pll_sleep_o(output_pll_sleep_o), .clock_dist_sleep_o(clock_dist_sleep_o),
  .full_sleep_o(full_sleep_o), .holdover_forced_o(holdover_forced_o),
  .freerun_forced_o(freerun_forced_o), .tune_source_o(tune_source_o),
  .lock_detect_hold_o(lock_detect_hold_o), .switch_mode_o(switch_mode_o),
  .manual_select_o(manual_select_o), .second_reference_o(second_reference_o));

`default_nettype wire

// file: testbench/test_operational_power_loop_control.sv
// testbench: register access, power-down decode, soft reset and loop mode
// assumes: loop_ctrl_regs answers each wishbone cycle one clock after it is taken
`default_nettype none

module test_operational_power_loop_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] PD = loop_ctrl_pkg::ADR_POWER_DOWN_CONTROL;
  localparam logic [13:0] LM = loop_ctrl_pkg::ADR_LOOP_MODE_CONTROL;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        hv = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] q;
  logic        e;
  wire  [31:0] rdat;
  wire  [7:0]  pd_v;
  wire  [2:0]  mode;
  wire  [1:0]  tune;
  wire         ack, err, hold, free, lock, man, sec;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          n;

  loop_ctrl_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
    .history_valid_i(hv), .soft_reset_o(pd_v[7]), .osc_sleep_o(pd_v[6]),
    .system_clock_input_sleep_o(pd_v[5]), .ref_inputs_sleep_o(pd_v[4]),
    .time_to_digital_converter_sleep_o(pd_v[3]),
    .output_pll_sleep_o(pd_v[2]), .clock_dist_sleep_o(pd_v[1]), .full_sleep_o(pd_v[0]),
    .holdover_forced_o(hold), .freerun_forced_o(free), .tune_source_o(tune),
    .lock_detect_hold_o(lock), .switch_mode_o(mode), .manual_select_o(man),
    .second_reference_o(sec));

  always #5 clk_i = ~clk_i;

  // ==========================================================================
  // helpers
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // holds the request until ack or err is sampled, then idles one cycle;
  // only the bench timeout ends a wait that never gets its answer
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1 && err !== 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================================================
  // sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({hold, free, lock, tune, mode, man, sec, pd_v}), 32'h0);
    bus(1'b0, PD, 8'h00);
    chk(q, 32'h0);
    for (int i = 1; i < 7; i++)
    begin
      bus(1'b1, PD, 8'(1 << i));
      chk(pd_v, 32'(1 << i));
      bus(1'b0, PD, 8'h00);
      chk(q, 32'(1 << i));
    end
    bus(1'b1, PD, 8'h01);
    chk(pd_v, 32'h7f);
    bus(1'b1, PD, 8'h84);
    // the sleep outputs clear one cycle after the pulse rises
    @(posedge clk_i);
    chk(pd_v, 32'h80);
    // one cycle of the pulse has already been seen before this count starts
    n = 1;
    while (pd_v[7] === 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n, 32'(loop_ctrl_pkg::SOFT_RESET_CYCLES));
    @(posedge clk_i);
    chk(pd_v, 32'h04);
    bus(1'b0, PD, 8'h00);
    chk(q, 32'h84);
    bus(1'b1, PD, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, LM, 8'({c[2:0], 2'b01}));
      chk(mode, (c > 4) ? 5 : c);
      chk({man, sec}, (c inside {2, 3, 4}) ? 2'b11 : 2'b00);
      bus(1'b0, LM, 8'h00);
      chk(q, 32'({c[2:0], 2'b01}));
    end
    bus(1'b1, LM, 8'hff);
    chk({free, hold, lock, tune}, {3'b100, 2'h2});
    bus(1'b0, LM, 8'h00);
    chk(q, 32'h7d);
    bus(1'b1, LM, 8'h40);
    chk({free, hold, lock, tune}, {3'b011, 2'h2});
    hv <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(tune, 2'h1);
    // a write without its byte lane must leave the register alone
    sel <= 4'h0;
    bus(1'b1, LM, 8'h20);
    sel <= 4'hf;
    bus(1'b0, LM, 8'h00);
    chk(q, 32'h40);
    bus(1'b0, 14'h2808, 8'h00);
    chk(e, 1'b1);
    finish_test();
  end
endmodule : test_operational_power_loop_control

`default_nettype wire
